// File: inc/remote_port_defs.vh
// Constants for the remote serial port and lockout block
// Assumes a 10 MHz core clock and a classic Wishbone slave
`ifndef REMOTE_PORT_DEFS_VH
`define REMOTE_PORT_DEFS_VH
`define CLK_HZ 32'd10000000
`define BAUD_1200 32'd1200
`define BAUD_2400 32'd2400
`define BAUD_9600 32'd9600
`define BAUD_19200 32'd19200
`define ADR_CONFIG 4'h0
`define ADR_STATUS 4'h1
`define ADR_TXDATA 4'h2
`define ADR_RXDATA 4'h3
`define ADR_LOCKCMD 4'h4
`define ADR_BUSMSG 4'h5
`define ADR_CAPS 4'h6
`define CFG_RESET 16'h0002
`define CAPS_VALUE 16'h007F
`define CH_LF 8'h0A
`define CH_XON 8'h11
`define CH_XOFF 8'h13
`define CH_SPACE 8'h20
`define CH_DEL 8'h7F
`endif

// File: rtl/remote_port_and_lockout.v
// Serial remote port, remote/local state and front panel lockout
// Assumes a classic Wishbone master on core_clk and rxd synchronous to core_clk
//
// Chosen here: the Wishbone register port and the address map.
`include "remote_port_defs.vh"
`timescale 1ns/1ps
module remote_port_and_lockout #(
  parameter CLK_RATE = `CLK_HZ
) (
  input wire core_clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rxd,
  output reg txd,
  output reg rts,
  output reg keyEnable,
  output reg displayEnable,
  output reg remoteMode
);
  // ==========================================================
  // Registers
  reg [15:0] cfgReg;
  reg [7:0] rxDataReg;
  reg rxValidReg;
  reg rxLineEndReg;
  reg rxOverrunReg;
  reg rxParityErrReg;
  reg rxFrameErrReg;
  reg txPausedReg;
  reg busLockReg;
  reg klockReg;
  reg dispOffReg;
  reg [7:0] txHoldReg;
  reg txHoldFullReg;
  wire [1:0] baudSel = cfgReg[1:0];
  wire eightBits = cfgReg[2];
  wire twoStops = cfgReg[3];
  wire parityOn = cfgReg[4];
  wire parityOdd = cfgReg[5];
  wire [4:0] busAddr = cfgReg[12:8];
  wire [3:0] regIdx = wb_adr_i[5:2];
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wrReq = busReq & wb_we_i & wb_sel_i[0];
  // ==========================================================
  // Bit timing
  reg [31:0] divisor;
  always @* begin
    case (baudSel)
      2'd0: divisor = CLK_RATE / `BAUD_1200;
      2'd1: divisor = CLK_RATE / `BAUD_2400;
      2'd2: divisor = CLK_RATE / `BAUD_9600;
      default: divisor = CLK_RATE / `BAUD_19200;
    endcase
  end
  // Counters run from the load value down to zero, so load one less than the bit time
  wire [15:0] bitTicks = divisor[15:0] - 16'h0001;
  wire [15:0] halfTicks = {1'b0, divisor[15:1]} - 16'h0001;
  wire [3:0] dataBits = eightBits ? 4'd8 : 4'd7;
  // ==========================================================
  // Receiver
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;
  reg [1:0] rxState;
  reg [15:0] rxCnt;
  reg [3:0] rxBit;
  reg [7:0] rxShift;
  reg rxPar;
  reg rxGotPar;
  wire [7:0] rxChar = eightBits ? rxShift : {1'b0, rxShift[7:1]};
  wire rxCtrl = (rxChar < `CH_SPACE) | (rxChar == `CH_DEL);
  wire rxRead = busReq & ~wb_we_i & (regIdx == `ADR_RXDATA);
  reg rxDone;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxState <= RX_IDLE;
      rxCnt <= 16'h0000;
      rxBit <= 4'h0;
      rxShift <= 8'h00;
      rxPar <= 1'b0;
      rxGotPar <= 1'b0;
      rxDone <= 1'b0;
      rxFrameErrReg <= 1'b0;
      rxParityErrReg <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          if (!rxd) begin
            rxState <= RX_START;
            rxCnt <= halfTicks;
          end
        end
        RX_START: begin
          if (rxCnt != 16'h0000) begin
            rxCnt <= rxCnt - 16'h0001;
          end else if (rxd) begin
            rxState <= RX_IDLE;
          end else begin
            rxState <= RX_DATA;
            rxCnt <= bitTicks;
            rxBit <= 4'h0;
            rxPar <= parityOdd;
          end
        end
        RX_DATA: begin
          if (rxCnt != 16'h0000) begin
            rxCnt <= rxCnt - 16'h0001;
          end else begin
            rxCnt <= bitTicks;
            rxBit <= rxBit + 4'h1;
            if (rxBit < dataBits) begin
              rxShift <= {rxd, rxShift[7:1]};
              rxPar <= rxPar ^ rxd;
            end else begin
              rxGotPar <= rxd;
            end
            if (rxBit == dataBits - {3'b000, ~parityOn}) begin
              rxState <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxCnt != 16'h0000) begin
            rxCnt <= rxCnt - 16'h0001;
          end else begin
            rxState <= RX_IDLE;
            rxDone <= 1'b1;
            rxFrameErrReg <= ~rxd;
            rxParityErrReg <= parityOn & (rxGotPar != rxPar);
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end
  wire rxFlow = rxDone & ((rxChar == `CH_XON) | (rxChar == `CH_XOFF));
  wire rxKeep = rxDone & ~rxFlow & (~rxCtrl | (rxChar == `CH_LF));
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rxDataReg <= 8'h00;
      rxValidReg <= 1'b0;
      rxLineEndReg <= 1'b0;
      rxOverrunReg <= 1'b0;
      txPausedReg <= 1'b0;
    end else begin
      if (rxFlow) begin
        txPausedReg <= (rxChar == `CH_XOFF);
      end
      if (rxKeep) begin
        rxDataReg <= rxChar;
        rxValidReg <= 1'b1;
        rxLineEndReg <= (rxChar == `CH_LF);
        rxOverrunReg <= rxOverrunReg | rxValidReg;
      end else if (rxRead) begin
        rxValidReg <= 1'b0;
        rxOverrunReg <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Transmitter
  localparam TX_IDLE = 2'd0;
  localparam TX_SEND = 2'd1;
  reg [1:0] txState;
  reg [15:0] txCnt;
  reg [11:0] txShift;
  reg [3:0] txLeft;
  wire txWrite = wrReq & (regIdx == `ADR_TXDATA);
  wire [7:0] txMasked = eightBits ? txHoldReg : {1'b0, txHoldReg[6:0]};
  wire txParBit = (^txMasked) ^ parityOdd;
  wire [3:0] txLen = dataBits + {3'b000, parityOn} + {3'b000, twoStops} + 4'd2;
  reg [11:0] txFrame;
  always @* begin
    txFrame = 12'hFFF;
    if (eightBits) begin
      txFrame[8:1] = txMasked;
      if (parityOn) begin
        txFrame[9] = txParBit;
      end
    end else begin
      txFrame[7:1] = txMasked[6:0];
      if (parityOn) begin
        txFrame[8] = txParBit;
      end
    end
    txFrame[0] = 1'b0;
  end
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      txCnt <= 16'h0000;
      txShift <= 12'hFFF;
      txLeft <= 4'h0;
      txd <= 1'b1;
      txHoldReg <= 8'h00;
      txHoldFullReg <= 1'b0;
      rts <= 1'b0;
    end else begin
      rts <= 1'b1;
      if (txWrite && !txHoldFullReg) begin
        txHoldReg <= wb_dat_i[7:0];
        txHoldFullReg <= 1'b1;
      end
      case (txState)
        TX_IDLE: begin
          txd <= 1'b1;
          if (txHoldFullReg && !txPausedReg) begin
            txShift <= txFrame;
            txLeft <= txLen;
            txCnt <= bitTicks;
            txHoldFullReg <= 1'b0;
            txState <= TX_SEND;
          end
        end
        TX_SEND: begin
          txd <= txShift[0];
          if (txCnt != 16'h0000) begin
            txCnt <= txCnt - 16'h0001;
          end else begin
            txCnt <= bitTicks;
            txShift <= {1'b1, txShift[11:1]};
            txLeft <= txLeft - 4'h1;
            if (txLeft == 4'h1) begin
              txState <= TX_IDLE;
            end
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Lockout control
  wire lockWr = wrReq & (regIdx == `ADR_LOCKCMD);
  wire msgWr = wrReq & (regIdx == `ADR_BUSMSG);
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busLockReg <= 1'b0;
      klockReg <= 1'b0;
      dispOffReg <= 1'b0;
      remoteMode <= 1'b0;
      keyEnable <= 1'b1;
      displayEnable <= 1'b1;
    end else begin
      if (msgWr) begin
        if (wb_dat_i[0]) begin
          remoteMode <= 1'b1;
        end
        if (wb_dat_i[1]) begin
          busLockReg <= 1'b1;
        end
        if (wb_dat_i[2] || wb_dat_i[3]) begin
          busLockReg <= 1'b0;
          remoteMode <= 1'b0;
        end
      end
      if (lockWr) begin
        if (wb_dat_i[0]) begin
          klockReg <= 1'b1;
        end else if (wb_dat_i[1]) begin
          klockReg <= 1'b0;
        end
        if (wb_dat_i[2] || wb_dat_i[3]) begin
          dispOffReg <= 1'b1;
        end else if (wb_dat_i[4]) begin
          dispOffReg <= 1'b0;
        end
      end
      keyEnable <= ~(busLockReg | klockReg | dispOffReg);
      displayEnable <= ~dispOffReg;
    end
  end
  // ==========================================================
  // Wishbone slave
  wire [15:0] statusWord = {4'h0, busLockReg, klockReg, dispOffReg, remoteMode,
    txHoldFullReg, txPausedReg, rxLineEndReg, rxFrameErrReg, rxParityErrReg,
    rxOverrunReg, ~txHoldFullReg, rxValidReg};
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfgReg <= `CFG_RESET;
    end else begin
      wb_ack_o <= busReq;
      if (wrReq && regIdx == `ADR_CONFIG) begin
        cfgReg <= {wb_sel_i[1] ? wb_dat_i[15:8] : cfgReg[15:8], wb_dat_i[7:0]};
      end
      if (busReq && !wb_we_i) begin
        case (regIdx)
          `ADR_CONFIG: wb_dat_o <= {16'h0000, cfgReg};
          `ADR_STATUS: wb_dat_o <= {16'h0000, statusWord};
          `ADR_TXDATA: wb_dat_o <= {24'h000000, txHoldReg};
          `ADR_RXDATA: wb_dat_o <= {24'h000000, rxDataReg};
          `ADR_CAPS: wb_dat_o <= {16'h0000, `CAPS_VALUE};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  wire unusedAddr = busAddr[0];
endmodule

// File: test/remote_port_monitor.sv
// Checker for the remote port and lockout block
// Sees only the top ports; bound after the module
`timescale 1ns/1ps
module remote_port_monitor (
  input wire core_clk,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire rxd,
  input wire txd,
  input wire rts,
  input wire keyEnable,
  input wire displayEnable,
  input wire remoteMode
);
  // ====================
  // Decoded bus writes
  wire takeReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrReq = takeReq && wb_we_i && wb_sel_i[0];
  wire lockWr = wrReq && wb_adr_i[5:2] == 4'h4;
  wire busWr = wrReq && wb_adr_i[5:2] == 4'h5;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ====================
  // Properties
  AST_ACK: assert property (takeReq |=> wb_ack_o) else $error("ack late");
  AST_RESET_LOCAL: assert property ($rose(rstn) |-> keyEnable && displayEnable && !remoteMode)
    else $error("not local after reset");
  AST_KLOCK: assert property (lockWr && wb_dat_i[0] |-> ##[1:3] !keyEnable)
    else $error("klock ignored");
  AST_DISP_OFF: assert property (lockWr && wb_dat_i[3:2] != 2'h0 |-> ##[1:3] !displayEnable && !keyEnable)
    else $error("display not blanked");
  AST_DISP_ON: assert property (lockWr && wb_dat_i[4:2] == 3'h4 |-> ##[1:3] displayEnable)
    else $error("display not restored");
  AST_LLO: assert property (busWr && wb_dat_i[3:1] == 3'h1 |-> ##[1:3] !keyEnable)
    else $error("bus lockout ignored");
  AST_REMOTE: assert property (busWr && wb_dat_i[3:0] == 4'h1 && keyEnable |-> ##[1:3] remoteMode && keyEnable)
    else $error("remote entry wrong");
  AST_KEY_FALL: assert property ($fell(keyEnable) |-> $past(wb_ack_o))
    else $error("key locked without bus write");
  AST_DISP_KEY: assert property (!displayEnable |-> !keyEnable) else $error("keys live, display off");
  COV_LOCK: cover property (lockWr ##[1:3] !keyEnable);
  COV_REMOTE: cover property ($rose(remoteMode));
  COV_TX: cover property ($fell(txd));
endmodule
bind remote_port_and_lockout remote_port_monitor remote_port_monitor_i (.core_clk(core_clk),
  .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd(rxd),
  .txd(txd), .rts(rts), .keyEnable(keyEnable), .displayEnable(displayEnable),
  .remoteMode(remoteMode));

// File: test/serial_host_model.sv
// Host computer on the serial line, 8N1
// Assumes the default bitCycles of 104 matches the block's rate; the bench never sets it
`timescale 1ns/1ps
module serial_host_model (
  input wire core_clk,
  input wire txd,
  output logic rxd
);
  int bitCycles = 104;
  int rxCount = 0;
  logic [7:0] rxByte;
  initial rxd = 1'b1;
  // ====================
  // Send one frame, LSB first
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (bitCycles) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (bitCycles) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (2 * bitCycles) @(posedge core_clk);
  endtask
  // ====================
  // Capture frames from the block
  always begin
    @(negedge txd);
    repeat (bitCycles / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitCycles) @(posedge core_clk);
      rxByte[i] = txd;
    end
    repeat (bitCycles) @(posedge core_clk);
    rxCount++;
  end
endmodule

// File: test/tb.sv
// Bench for the remote port and lockout block
// Drives Wishbone and a serial host model at the 9600 baud setting, 104 clocks per bit
`include "remote_port_defs.vh"
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [5:0] wbAdr = 6'h00;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] rd;
  logic [7:0] b;
  logic kl = 0, dOff = 0, bLock = 0, rem = 0;
  wire [31:0] wbDatO;
  wire wbAck, rxd, txd, rts, keyEnable, displayEnable, remoteMode;
  int failures = 0, num_checks = 0, cycles = 0, op, n0;
  int ops[11] = '{0, 2, 1, 4, 5, 3, 6, 8, 4, 6, 7};
  always #50 core_clk = ~core_clk;
  remote_port_and_lockout #(.CLK_RATE(32'h000f_4240)) remote_port_and_lockout_i (
    .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .rxd(rxd), .txd(txd), .rts(rts), .keyEnable(keyEnable), .displayEnable(displayEnable),
    .remoteMode(remoteMode));
  serial_host_model serial_host_model_i (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  // ====================
  // Tasks
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    @(posedge core_clk);
    while (wbAck !== 1'b1) @(posedge core_clk);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic waitTx;
    for (int k = 0; k < 3000 && serial_host_model_i.rxCount == n0; k++) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      conclude();
    end
  end
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h5d52));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("key", 1, keyEnable);
    check("disp", 1, displayEnable);
    check("remote", 0, remoteMode);
    check("rts", 1, rts);
    wb(0, 6'h00, 0);
    check("config", 32'h0000_0002, rd);
    wb(0, 6'h18, 0);
    check("caps", 32'h0000_007f, rd);
    wb(0, 6'h3c, 0);
    check("unmapped", 0, rd);
    wb(1, 6'h00, 32'h0000_0a06);
    wb(0, 6'h00, 0);
    check("config", 32'h0000_0a06, rd);
    for (int i = 0; i < 21; i++) begin
      op = i < 11 ? ops[i] : $urandom % 9;
      wb(1, op < 5 ? 6'h10 : 6'h14, 32'h1 << (op < 5 ? op : op - 5));
      case (op)
        0, 1: kl = op == 0;
        2, 3, 4: dOff = op != 4;
        5: rem = 1;
        default: begin
          bLock = op == 6;
          rem = rem && op == 6;
        end
      endcase
      check("key", !(kl | dOff | bLock), keyEnable);
      check("disp", !dOff, displayEnable);
      check("remote", rem, remoteMode);
    end
    b = 8'h20 + $urandom % 95;
    serial_host_model_i.send(b);
    wb(0, 6'h0c, 0);
    check("rx", b, rd[7:0]);
    serial_host_model_i.send(8'h0d);
    wb(0, 6'h04, 0);
    check("rx valid", 0, rd[0]);
    serial_host_model_i.send(`CH_LF);
    wb(0, 6'h04, 0);
    check("lf seen", 1, rd[5]);
    wb(0, 6'h0c, 0);
    check("rx", `CH_LF, rd[7:0]);
    serial_host_model_i.send(`CH_XOFF);
    wb(0, 6'h04, 0);
    check("paused", 1, rd[6]);
    check("rx valid", 0, rd[0]);
    n0 = serial_host_model_i.rxCount;
    b = $urandom;
    wb(1, 6'h08, b);
    repeat (1500) @(posedge core_clk);
    check("held", n0, serial_host_model_i.rxCount);
    serial_host_model_i.send(`CH_XON);
    waitTx();
    check("tx", b, serial_host_model_i.rxByte);
    conclude();
  end
endmodule
